/* File: core/sspal_consts.svh */
// Offsets, field positions, reset values and codes of the split screen and palette registers
`ifndef SSPAL_CONSTS_SVH
`define SSPAL_CONSTS_SVH
// Register indices; the byte address is four times the index
`define SSPAL_IDX_S2_LOW 6'h0E
`define SSPAL_IDX_S2_HIGH 6'h0F
`define SSPAL_IDX_OVF 6'h10
`define SSPAL_IDX_OFFSET 6'h11
`define SSPAL_IDX_H1_LOW 6'h12
`define SSPAL_IDX_H1_HIGH 6'h13
`define SSPAL_IDX_PAL_IDX 6'h15
`define SSPAL_IDX_PAL_DATA 6'h17
`define SSPAL_IDX_MODE 6'h20
`define SSPAL_IDX_PANEL 6'h21
// Field positions
`define SSPAL_OVF_BIT 0
`define SSPAL_ROT_BIT 0
`define SSPAL_COMP_LSB 4
// Reset values
`define SSPAL_RST_BYTE 8'h00
`define SSPAL_RST_HEIGHT 10'h3FF
`define SSPAL_RST_PANEL 10'h000
// Bus response codes
`define SSPAL_RESP_OKAY 2'h0
`define SSPAL_RESP_SLVERR 2'h2
`endif

/* File: core/sspal_pkg.sv */
// Types shared by the split screen and palette register bank
package sspal_pkg;
    typedef enum logic [1:0] {comp_red, comp_green, comp_blue} sspal_comp_t;
    typedef logic [3:0] sspal_colour_t;
endpackage

/* File: core/sspal_regs.sv */
// Split screen, virtual image and colour palette registers behind an AXI4-Lite slave
//
// Overview of operation
// - Second screen start: 16-bit word, landscape only
// - Overflow bit 0 is rotated start bit 16
// - Landscape line offset forms wider virtual image
// - First screen height is ten bits, two bytes
// - Lines 0..n first screen, rest second
// - Three 256-entry 4-bit colour palette tables
// - Index write loads pointer, selects red
// - Data access steps red, green, blue, next
// - Red and green staged, committed on blue
// - Component sits in data bits 7..4
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "sspal_consts.svh"
module sspal_regs (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic [9:0] display_line,
    input wire logic [7:0] pixel_index,
    output logic [15:0] screen2_start,
    output logic screen1_start_bit16,
    output logic [7:0] line_offset,
    output logic [9:0] screen1_height,
    output logic split_active,
    output logic show_screen2,
    output sspal_pkg::sspal_colour_t pixel_red,
    output sspal_pkg::sspal_colour_t pixel_green,
    output sspal_pkg::sspal_colour_t pixel_blue
);
    import sspal_pkg::*;

    // Bus channel state
    logic aw_held, w_held, ar_pend, w_lane0;
    logic [5:0] aw_idx, ar_idx;
    logic [7:0] w_byte;
    logic [1:0] w_hi2, next_w_hi2;
    logic next_aw_held, next_w_held, next_ar_pend, next_w_lane0;
    logic [5:0] next_aw_idx, next_ar_idx;
    logic [7:0] next_w_byte;
    logic next_awready, next_wready, next_arready, next_bvalid, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;
    // Configuration state
    logic [7:0] s2_low, s2_high, offset;
    logic ovf_bit, rotated;
    logic [9:0] h1, panel;
    logic [7:0] next_s2_low, next_s2_high, next_offset;
    logic next_ovf_bit, next_rotated;
    logic [9:0] next_h1, next_panel;
    // Palette pointer and staging
    logic [7:0] ptr, next_ptr, step_ptr;
    sspal_comp_t comp, next_comp, step_comp;
    sspal_colour_t stage_r, stage_g, next_stage_r, next_stage_g;
    // Display facing outputs
    logic [15:0] next_screen2_start;
    logic next_bit16, next_split, next_show2;
    logic [7:0] next_line_offset;
    sspal_colour_t next_pix_r, next_pix_g, next_pix_b;
    // Palette commit port
    logic pal_we;
    logic [7:0] pal_addr;
    sspal_colour_t pal_r, pal_g, pal_b;
    // Palette tables, one per colour
    sspal_colour_t red_tab [256];
    sspal_colour_t green_tab [256];
    sspal_colour_t blue_tab [256];
    logic do_write, do_read, split_now;
    sspal_colour_t cur_comp, new_comp;

    // Bus slave, register file and palette pointer next values
    always_comb
    begin
        next_aw_held = aw_held;
        next_aw_idx = aw_idx;
        next_w_held = w_held;
        next_w_byte = w_byte;
        next_w_lane0 = w_lane0;
        next_w_hi2 = w_hi2;
        next_ar_pend = ar_pend;
        next_ar_idx = ar_idx;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_rvalid = rvalid;
        next_rresp = rresp;
        next_rdata = rdata;
        next_s2_low = s2_low;
        next_s2_high = s2_high;
        next_offset = offset;
        next_ovf_bit = ovf_bit;
        next_rotated = rotated;
        next_h1 = h1;
        next_panel = panel;
        next_ptr = ptr;
        next_comp = comp;
        next_stage_r = stage_r;
        next_stage_g = stage_g;
        pal_we = 1'b0;
        pal_addr = ptr;
        pal_r = stage_r;
        pal_g = stage_g;
        pal_b = 4'h0;
        new_comp = w_byte[`SSPAL_COMP_LSB +: 4];
        cur_comp = (comp == comp_red) ? red_tab[ptr] :
            (comp == comp_green) ? green_tab[ptr] : blue_tab[ptr];
        // Pointer step: red, green, blue, then red of the following entry
        step_ptr = (comp == comp_blue) ? ptr + 8'h01 : ptr;
        step_comp = (comp == comp_red) ? comp_green : (comp == comp_green) ? comp_blue : comp_red;
        // Address and data are taken in either order
        if (awvalid && awready)
        begin
            next_aw_held = 1'b1;
            next_aw_idx = awaddr[7:2];
        end
        if (wvalid && wready)
        begin
            next_w_held = 1'b1;
            next_w_byte = wdata[7:0];
            next_w_lane0 = wstrb[0];
            next_w_hi2 = wdata[9:8];
        end
        do_write = aw_held && w_held && !bvalid;
        // A write in progress holds off a read so the pointer steps once per access
        do_read = ar_pend && !do_write && !rvalid;
        if (bvalid && bready) next_bvalid = 1'b0;
        if (do_write)
        begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = `SSPAL_RESP_OKAY;
            unique case (aw_idx)
                `SSPAL_IDX_S2_LOW:
                    if (w_lane0) next_s2_low = w_byte;
                `SSPAL_IDX_S2_HIGH:
                    if (w_lane0) next_s2_high = w_byte;
                `SSPAL_IDX_OVF:
                    if (w_lane0) next_ovf_bit = w_byte[`SSPAL_OVF_BIT];
                `SSPAL_IDX_OFFSET:
                    if (w_lane0) next_offset = w_byte;
                `SSPAL_IDX_H1_LOW:
                    if (w_lane0) next_h1[7:0] = w_byte;
                `SSPAL_IDX_H1_HIGH:
                    if (w_lane0) next_h1[9:8] = w_byte[1:0];
                `SSPAL_IDX_MODE:
                    if (w_lane0) next_rotated = w_byte[`SSPAL_ROT_BIT];
                `SSPAL_IDX_PANEL:
                    if (w_lane0) next_panel = {w_hi2, w_byte}; // Ten bits from the low word
                `SSPAL_IDX_PAL_IDX:
                    if (w_lane0)
                    begin
                        next_ptr = w_byte;
                        next_comp = comp_red;
                    end
                `SSPAL_IDX_PAL_DATA:
                    if (w_lane0)
                    begin
                        unique case (comp)
                            comp_red: next_stage_r = new_comp;
                            comp_green: next_stage_g = new_comp;
                            comp_blue:
                            begin
                                pal_we = 1'b1;
                                pal_b = new_comp;
                            end
                            default: next_comp = comp_red;
                        endcase
                        next_ptr = step_ptr;
                        next_comp = step_comp;
                    end
                default: next_bresp = `SSPAL_RESP_SLVERR;
            endcase
        end
        if (rvalid && rready) next_rvalid = 1'b0;
        if (arvalid && arready)
        begin
            next_ar_pend = 1'b1;
            next_ar_idx = araddr[7:2];
        end
        if (do_read)
        begin
            next_ar_pend = 1'b0;
            next_rvalid = 1'b1;
            next_rresp = `SSPAL_RESP_OKAY;
            next_rdata = 32'h0000_0000;
            unique case (ar_idx)
                `SSPAL_IDX_S2_LOW: next_rdata[7:0] = s2_low;
                `SSPAL_IDX_S2_HIGH: next_rdata[7:0] = s2_high;
                `SSPAL_IDX_OVF: next_rdata[`SSPAL_OVF_BIT] = ovf_bit;
                `SSPAL_IDX_OFFSET: next_rdata[7:0] = offset;
                `SSPAL_IDX_H1_LOW: next_rdata[7:0] = h1[7:0];
                `SSPAL_IDX_H1_HIGH: next_rdata[1:0] = h1[9:8];
                `SSPAL_IDX_MODE: next_rdata[`SSPAL_ROT_BIT] = rotated;
                `SSPAL_IDX_PANEL: next_rdata[9:0] = panel;
                // Reading the index shows where the pointer has moved to
                `SSPAL_IDX_PAL_IDX: next_rdata[7:0] = ptr;
                `SSPAL_IDX_PAL_DATA:
                begin
                    next_rdata[`SSPAL_COMP_LSB +: 4] = cur_comp;
                    next_ptr = step_ptr;
                    next_comp = step_comp;
                end
                default: next_rresp = `SSPAL_RESP_SLVERR;
            endcase
        end
        next_awready = !next_aw_held;
        next_wready = !next_w_held;
        next_arready = !next_ar_pend && !next_rvalid;
    end

    // Display facing values; orientation gates the landscape-only fields
    always_comb
    begin
        split_now = !rotated && (h1 < panel);
        next_split = split_now;
        next_show2 = split_now && (display_line > h1);
        next_screen2_start = rotated ? 16'h0000 : {s2_high, s2_low};
        next_bit16 = rotated && ovf_bit;
        next_line_offset = rotated ? 8'h00 : offset;
        next_pix_r = red_tab[pixel_index];
        next_pix_g = green_tab[pixel_index];
        next_pix_b = blue_tab[pixel_index];
    end

    // Control and output registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            aw_idx <= 6'h00;
            w_held <= 1'b0;
            w_byte <= `SSPAL_RST_BYTE;
            w_lane0 <= 1'b0;
            w_hi2 <= 2'h0;
            ar_pend <= 1'b0;
            ar_idx <= 6'h00;
            awready <= 1'b0;
            wready <= 1'b0;
            arready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= `SSPAL_RESP_OKAY;
            rvalid <= 1'b0;
            rresp <= `SSPAL_RESP_OKAY;
            rdata <= 32'h0000_0000;
            s2_low <= `SSPAL_RST_BYTE;
            s2_high <= `SSPAL_RST_BYTE;
            offset <= `SSPAL_RST_BYTE;
            ovf_bit <= 1'b0;
            rotated <= 1'b0;
            h1 <= `SSPAL_RST_HEIGHT;
            panel <= `SSPAL_RST_PANEL;
            ptr <= `SSPAL_RST_BYTE;
            comp <= comp_red;
            stage_r <= 4'h0;
            stage_g <= 4'h0;
            screen2_start <= 16'h0000;
            screen1_start_bit16 <= 1'b0;
            line_offset <= `SSPAL_RST_BYTE;
            screen1_height <= `SSPAL_RST_HEIGHT;
            split_active <= 1'b0;
            show_screen2 <= 1'b0;
            pixel_red <= 4'h0;
            pixel_green <= 4'h0;
            pixel_blue <= 4'h0;
        end
        else
        begin
            aw_held <= next_aw_held;
            aw_idx <= next_aw_idx;
            w_held <= next_w_held;
            w_byte <= next_w_byte;
            w_lane0 <= next_w_lane0;
            w_hi2 <= next_w_hi2;
            ar_pend <= next_ar_pend;
            ar_idx <= next_ar_idx;
            awready <= next_awready;
            wready <= next_wready;
            arready <= next_arready;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            rvalid <= next_rvalid;
            rresp <= next_rresp;
            rdata <= next_rdata;
            s2_low <= next_s2_low;
            s2_high <= next_s2_high;
            offset <= next_offset;
            ovf_bit <= next_ovf_bit;
            rotated <= next_rotated;
            h1 <= next_h1;
            panel <= next_panel;
            ptr <= next_ptr;
            comp <= next_comp;
            stage_r <= next_stage_r;
            stage_g <= next_stage_g;
            screen2_start <= next_screen2_start;
            screen1_start_bit16 <= next_bit16;
            line_offset <= next_line_offset;
            screen1_height <= h1;
            split_active <= next_split;
            show_screen2 <= next_show2;
            pixel_red <= next_pix_r;
            pixel_green <= next_pix_g;
            pixel_blue <= next_pix_b;
        end
    end

    // Whole entry lands at once, so the display never sees a half-written colour
    always_ff @(posedge aclk)
    begin
        if (pal_we)
        begin
            red_tab[pal_addr] <= pal_r;
            green_tab[pal_addr] <= pal_g;
            blue_tab[pal_addr] <= pal_b;
        end
    end
endmodule

/* File: verification/sspal_asserts.sv */
// Checker for the split screen and palette register bank, bound to its ports
`timescale 1ns/1ps
module sspal_asserts (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic [15:0] screen2_start,
    input wire logic screen1_start_bit16,
    input wire logic [7:0] line_offset,
    input wire logic split_active,
    input wire logic show_screen2
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // Bit 16 only shows in rotated mode, where landscape outputs must read zero
    a_rot_clear: assert property (
        screen1_start_bit16 |-> screen2_start == 16'h0000 && line_offset == 8'h00)
        else $error("landscape output live while rotated");
    a_rot_nosplit: assert property (
        screen1_start_bit16 |-> !split_active) else $error("split while rotated");
    a_show_split: assert property (
        show_screen2 |-> split_active) else $error("second screen without split");
    a_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped early");
    a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped early");
    a_aw_taken: assert property (awvalid && awready |=> !awready)
        else $error("second address taken while one held");
    a_r_busy: assert property (rvalid |-> !arready) else $error("read taken while pending");
    a_r_answer: assert property (arvalid && arready |-> ##[1:3] rvalid)
        else $error("read not answered");
    // Panel size is the widest field, so a stray bit above it means a decode slip
    a_rdata_low: assert property (
        rvalid |-> rdata[31:10] == 22'h0) else $error("upper read bits set");
    c_write: cover property (bvalid && bready);
    c_read: cover property (rvalid && rready);
    c_rot: cover property (screen1_start_bit16);
    c_split: cover property (show_screen2);
endmodule
bind sspal_regs sspal_asserts u_chk (.aclk, .aresetn, .awvalid, .awready, .bresp, .bvalid,
    .bready, .arvalid, .arready, .rdata, .rvalid, .rready, .screen2_start,
    .screen1_start_bit16, .line_offset, .split_active, .show_screen2);

/* File: verification/sspal_scan.sv */
// Display side raster walker that feeds line numbers and palette lookups
`timescale 1ns/1ps
module sspal_scan (
    input wire logic aclk,
    input wire logic aresetn,
    output logic [9:0] display_line,
    output logic [7:0] pixel_index
);
    logic [9:0] next_line;
    logic [7:0] next_pix;
    // One lookup per clock; a new line after every 256 lookups
    always_comb
    begin
        next_pix = pixel_index + 8'h01;
        next_line = display_line + {9'h000, &pixel_index};
    end
    always_ff @(posedge aclk)
    begin
        display_line <= aresetn ? next_line : 10'h000;
        pixel_index <= aresetn ? next_pix : 8'h00;
    end
endmodule

/* File: verification/testbench.sv */
// Bus level testbench for the split screen and palette register bank
`timescale 1ns/1ps
`include "sspal_consts.svh"
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_mismatch++; \
    $display("wrong value at %0t: got %h expected %h", $time, a, e); end end
module testbench;
    import sspal_pkg::*;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, screen1_start_bit16;
    logic split_active, show_screen2;
    logic [7:0] awaddr, araddr, pixel_index, line_offset;
    logic [31:0] wdata, rdata, rd_data;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rsp;
    logic [9:0] display_line, screen1_height;
    logic [15:0] screen2_start;
    logic [9:0] ln;
    sspal_colour_t pixel_red, pixel_green, pixel_blue;
    int n_mismatch = 0;
    int checks_done = 0;
    sspal_regs u_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
        .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
        .rvalid, .rready, .display_line, .pixel_index, .screen2_start, .screen1_start_bit16,
        .line_offset, .screen1_height, .split_active, .show_screen2, .pixel_red,
        .pixel_green, .pixel_blue);
    sspal_scan u_scan (.aclk, .aresetn, .display_line, .pixel_index);
    initial
    begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    // Address and data offered together, each released once taken
    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        awaddr <= {idx, 2'b00};
        wdata <= {24'h000000, d};
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        rsp = bresp;
        bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rd(input logic [5:0] idx);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rd_data = rdata;
        rsp = rresp;
        rready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic conclude;
        $display("mismatches %0d, checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Hang guard; the whole sequence needs under two thousand cycles
    initial
    begin
        repeat (5000) @(posedge aclk);
        n_mismatch++;
        conclude();
    end
    initial
    begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {awaddr, araddr, wdata, wstrb} = 52'h0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        `CHK(screen1_height, `SSPAL_RST_HEIGHT)
        wr(`SSPAL_IDX_S2_LOW, 8'h34);
        wr(`SSPAL_IDX_S2_HIGH, 8'h12);
        wr(`SSPAL_IDX_OFFSET, 8'h5A);
        wr(`SSPAL_IDX_H1_LOW, 8'hCE);
        wr(`SSPAL_IDX_H1_HIGH, 8'hFD);
        wr(`SSPAL_IDX_OVF, 8'h01);
        `CHK(screen2_start, 16'h1234)
        `CHK(line_offset, 8'h5A)
        `CHK(screen1_height, 10'h1CE)
        `CHK(screen1_start_bit16, 1'b0)
        rd(`SSPAL_IDX_H1_LOW);
        `CHK(rd_data, 32'h000000CE)
        // Software keeps the height at or above the panel before rotating
        wr(`SSPAL_IDX_H1_LOW, 8'hFF);
        wr(`SSPAL_IDX_H1_HIGH, 8'h03);
        `CHK(split_active, 1'b0)
        wr(`SSPAL_IDX_MODE, 8'h01);
        `CHK(screen2_start, 16'h0000)
        `CHK(line_offset, 8'h00)
        `CHK(screen1_start_bit16, 1'b1)
        wr(`SSPAL_IDX_MODE, 8'h00);
        `CHK(screen1_start_bit16, 1'b0)
        // Entry 255 then entry 0, crossing the pointer wrap in one burst
        wr(`SSPAL_IDX_PAL_IDX, 8'hFF);
        for (int i = 1; i < 7; i++) wr(`SSPAL_IDX_PAL_DATA, 8'(i << 4));
        rd(`SSPAL_IDX_PAL_IDX);
        `CHK(rd_data, 32'h00000001)
        wr(`SSPAL_IDX_PAL_IDX, 8'hFF);
        for (int i = 1; i < 5; i++)
        begin
            rd(`SSPAL_IDX_PAL_DATA);
            `CHK(rd_data, 32'(i << 4))
        end
        // Red and green without blue must leave the table untouched
        wr(`SSPAL_IDX_PAL_IDX, 8'h00);
        wr(`SSPAL_IDX_PAL_DATA, 8'hF0);
        wr(`SSPAL_IDX_PAL_DATA, 8'hE0);
        wr(`SSPAL_IDX_PAL_IDX, 8'h00);
        rd(`SSPAL_IDX_PAL_DATA);
        `CHK(rd_data, 32'h00000040)
        rd(`SSPAL_IDX_PAL_DATA);
        `CHK(rd_data, 32'h00000050)
        // Lookup of entry 255 shows one clock after its index, looked at mid-cycle
        do @(negedge aclk); while (pixel_index !== 8'hFF);
        @(negedge aclk);
        `CHK({pixel_red, pixel_green, pixel_blue}, 12'h123)
        @(posedge aclk);
        rd(6'h3F);
        `CHK({rsp, rd_data}, {`SSPAL_RESP_SLVERR, 32'h0})
        wr(6'h3F, 8'hAA);
        `CHK(rsp, `SSPAL_RESP_SLVERR)
        // Height n below the panel size: line n is first screen, line n+1 second
        wr(`SSPAL_IDX_PANEL, 8'hF0);
        ln = display_line + 10'h001;
        wr(`SSPAL_IDX_H1_HIGH, {6'h00, ln[9:8]});
        wr(`SSPAL_IDX_H1_LOW, ln[7:0]);
        `CHK(split_active, 1'b1)
        do @(negedge aclk); while (display_line !== ln);
        @(negedge aclk);
        `CHK(show_screen2, 1'b0)
        do @(negedge aclk); while (display_line !== ln + 10'h001);
        @(negedge aclk);
        `CHK(show_screen2, 1'b1)
        @(posedge aclk);
        conclude();
    end
endmodule
